// file: rtl/ddr_map.vh
// Purpose: constants for the DDR command engine
// Assumes: 50 MHz system clock samples every link pin
// Notes: times in ns, cycle counts derived and rounded up
`ifndef DDR_MAP_VH
`define DDR_MAP_VH

// Command codes as {ras_n, cas_n, we_n}
`define CMD_LMR 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_BST 3'h6
`define CMD_NOP 3'h7

// Address bit roles
`define AP_BIT 10
`define DLL_RST_BIT 8

// Register port map
`define REG_CONFIG 2'h0
`define REG_STATUS 2'h1
`define CFG_CL_BIT 0
`define CFG_BL_LO 1
`define CFG_BL_HI 2
`define CONFIG_RESET 8'h05

// Read latency in half clock edges
`define CL2_EDGES 3'h4
`define CL25_EDGES 3'h5

// Timing figures in ns and derived counts
`define CLK_MHZ 50
`define T_RP_NS 20
`define T_RAS_NS 45
`define T_RFC_NS 75
`define T_XSNR_NS 75
`define CYC_UP(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define T_RP_CYC `CYC_UP(`T_RP_NS)
`define T_RAS_CYC `CYC_UP(`T_RAS_NS)
`define T_RFC_CYC `CYC_UP(`T_RFC_NS)
`define T_XSNR_CYC `CYC_UP(`T_XSNR_NS)
`define DLL_LOCK_CK 8'hC8

`endif

// file: rtl/bank_tracker.v
// Purpose: state of one bank: idle, open row, precharging
// Assumes: commands arrive as one-cycle pulses
// Notes: auto precharge waits for the least row-open time
`timescale 1ns/1ps
`default_nettype none
`include "ddr_map.vh"
module bank_tracker (
  input wire clock_in, // System clock
  input wire rst_n_in, // Synchronous reset, active low
  input wire activate_in, // Open a row
  input wire precharge_in, // Explicit precharge
  input wire auto_pre_in, // Auto precharge request
  output reg open_out, // Row open
  output reg idle_out // Bank idle
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_OPEN = 3'h2;
  localparam [2:0] ST_PRE = 3'h4;
  localparam integer RAS_I = `T_RAS_CYC;
  localparam integer RP_I = `T_RP_CYC;

  reg [2:0] state;
  reg [7:0] ras_cnt;
  reg [7:0] rp_cnt;
  reg ap_pend;

  // Bank state walk with row-open and precharge timers
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      ras_cnt <= 8'h00;
      rp_cnt <= 8'h00;
      ap_pend <= 1'b0;
      open_out <= 1'b0;
      idle_out <= 1'b1;
    end else begin
      if (ras_cnt != 8'h00)
        ras_cnt <= ras_cnt - 8'h01;
      case (state)
        ST_IDLE: begin
          ap_pend <= 1'b0;
          if (activate_in) begin
            state <= ST_OPEN;
            ras_cnt <= RAS_I[7:0];
            open_out <= 1'b1;
            idle_out <= 1'b0;
          end
        end
        ST_OPEN: begin
          if (auto_pre_in)
            ap_pend <= 1'b1;
          if (precharge_in ||
              (ap_pend && ras_cnt == 8'h00)) begin
            state <= ST_PRE;
            rp_cnt <= RP_I[7:0];
            open_out <= 1'b0;
            ap_pend <= 1'b0;
          end
        end
        ST_PRE: begin
          // A second precharge here does nothing
          if (rp_cnt > 8'h01) begin
            rp_cnt <= rp_cnt - 8'h01;
          end else begin
            state <= ST_IDLE;
            rp_cnt <= 8'h00;
            idle_out <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          open_out <= 1'b0;
          idle_out <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/ddr_command_engine.v
// Purpose: command decode, bank states and data path of a DDR memory
// Assumes: link pins are asynchronous, CK runs far below clock_in
// Notes: x8 data, 256-byte array indexed by bank and low column bits
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_map.vh"
module ddr_command_engine (
  input wire clock_in, // System clock, 50 MHz
  input wire rst_n_in, // Synchronous reset, active low
  input wire ck_in, // Link clock pin
  input wire cke_in, // Clock enable pin
  input wire cs_n_in, // Chip select, active low
  input wire ras_n_in, // Row strobe, active low
  input wire cas_n_in, // Column strobe, active low
  input wire we_n_in, // Write enable, active low
  input wire [1:0] ba_in, // Bank address
  input wire [13:0] addr_in, // Row or column address
  input wire [7:0] dq_in, // Data pins, input side
  input wire dqs_in, // Strobe pin, input side
  input wire dm_in, // Write data mask
  output reg [7:0] dq_out, // Data pins, output side
  output reg dq_oe_out, // Data pins driven
  output reg dqs_out, // Strobe pin, output side
  output reg dqs_oe_out, // Strobe pin driven
  input wire [1:0] reg_addr_in, // Register address
  input wire [7:0] reg_wdata_in, // Register write data
  input wire reg_wr_in, // Register write strobe
  input wire reg_rd_in, // Register read strobe
  output reg [7:0] reg_rdata_out // Register read data
);
  localparam [2:0] M_RUN = 3'h1;
  localparam [2:0] M_SREF = 3'h2;
  localparam [2:0] M_XSNR = 3'h4;
  localparam integer RFC_I = `T_RFC_CYC;
  localparam integer XSNR_I = `T_XSNR_CYC;

  // Two-stage synchroniser on every link pin
  wire [31:0] pin_raw;
  reg [31:0] pin_s1;
  reg [31:0] pin_s2;
  assign pin_raw = {ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in,
                    we_n_in, ba_in, addr_in, dq_in, dqs_in, dm_in};
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      pin_s1 <= 32'h7C000000; // Idle levels: CKE and command pins high
      pin_s2 <= 32'h7C000000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire ck_s = pin_s2[31];
  wire cke_s = pin_s2[30];
  wire cs_n_s = pin_s2[29];
  wire [2:0] cmd = pin_s2[28:26];
  wire [1:0] ba_s = pin_s2[25:24];
  wire [13:0] addr_s = pin_s2[23:10];
  wire [7:0] dq_s = pin_s2[9:2];
  wire dqs_s = pin_s2[1];
  wire dm_s = pin_s2[0];

  // Edge finders on the synchronised clock and strobe
  reg ck_d;
  reg dqs_d;
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      ck_d <= 1'b0;
      dqs_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
      dqs_d <= dqs_s;
    end
  end
  wire ck_rise = ck_s & ~ck_d;
  wire ck_edge = ck_s ^ ck_d;
  wire dqs_edge = (dqs_s ^ dqs_d) & ~dqs_oe_out;

  // Configuration and engine state
  reg [7:0] config_reg;
  reg [2:0] mode;
  reg [7:0] ref_cnt;
  reg [7:0] xs_cnt;
  reg dll_ok;
  reg [7:0] dll_cnt;
  wire ref_busy = (ref_cnt != 8'h00);
  wire [1:0] bl_code = config_reg[`CFG_BL_HI:`CFG_BL_LO];
  wire [3:0] bl_len = (bl_code == 2'h3) ? 4'h8 :
                      (bl_code == 2'h2) ? 4'h4 : 4'h2;
  wire [2:0] bl_mask = bl_len[2:0] - 3'h1;

  // Bank state from the four trackers
  wire [3:0] bank_open;
  wire [3:0] bank_idle;
  wire all_idle = &bank_idle;

  // Command qualification at each registered clock rise
  wire sel = ck_rise & ~cs_n_s & (mode == M_RUN);
  wire go = sel & cke_s;
  wire is_act = go & (cmd == `CMD_ACT);
  wire is_pre = go & (cmd == `CMD_PRE);
  wire ba_open = bank_open[ba_s];
  wire rd_ok = go & (cmd == `CMD_READ) & ba_open & dll_ok & ~ref_busy;
  wire wr_ok = go & (cmd == `CMD_WRITE) & ba_open & ~ref_busy;
  wire ref_ok = go & (cmd == `CMD_REF) & all_idle & ~ref_busy;
  wire sref_ok = sel & ~cke_s & (cmd == `CMD_REF) & all_idle &
                 ~ref_busy;
  wire dll_rst = go & (cmd == `CMD_LMR) & (ba_s == 2'h0) &
                 addr_s[`DLL_RST_BIT];
  wire [3:0] act_vec = is_act ? (4'h1 << ba_s) : 4'h0;
  wire [3:0] pre_vec = !is_pre ? 4'h0 :
                       addr_s[`AP_BIT] ? 4'hF : (4'h1 << ba_s);
  reg [3:0] ap_vec;

  // One tracker per bank
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      bank_tracker u_bank (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .activate_in(act_vec[gi]),
        .precharge_in(pre_vec[gi]),
        .auto_pre_in(ap_vec[gi]),
        .open_out(bank_open[gi]),
        .idle_out(bank_idle[gi])
      );
    end
  endgenerate

  // Column of element idx, wrapping inside the burst block
  function [5:0] burst_col;
    input [5:0] base;
    input [3:0] idx;
    input [2:0] mask;
    reg [2:0] sum;
    begin
      sum = base[2:0] + idx[2:0];
      burst_col = {base[5:3], (base[2:0] & ~mask) | (sum & mask)};
    end
  endfunction

  // Self refresh, exit wait, refresh period and DLL lock
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      mode <= M_RUN;
      ref_cnt <= 8'h00;
      xs_cnt <= 8'h00;
      dll_ok <= 1'b1;
      dll_cnt <= 8'h00;
    end else begin
      if (ref_ok)
        ref_cnt <= RFC_I[7:0];
      else if (ref_busy)
        ref_cnt <= ref_cnt - 8'h01;
      if (dll_rst) begin
        dll_cnt <= `DLL_LOCK_CK;
      end else if (ck_rise && dll_cnt != 8'h00) begin
        dll_cnt <= dll_cnt - 8'h01;
        if (dll_cnt == 8'h01)
          dll_ok <= 1'b1;
      end
      case (mode)
        M_RUN: begin
          if (sref_ok) begin
            mode <= M_SREF;
            dll_ok <= 1'b0;
            dll_cnt <= 8'h00;
          end
        end
        M_SREF: begin
          // Only CKE is watched here
          if (cke_s) begin
            mode <= M_XSNR;
            xs_cnt <= XSNR_I[7:0];
          end
        end
        M_XSNR: begin
          if (xs_cnt > 8'h01)
            xs_cnt <= xs_cnt - 8'h01;
          else
            mode <= M_RUN;
        end
        default: mode <= M_RUN;
      endcase
    end
  end

  // Read burst state
  reg [2:0] rd_wait;
  reg [3:0] rd_cnt;
  reg [3:0] rd_lim;
  reg [2:0] rd_age;
  reg [5:0] rd_base;
  reg [1:0] rd_bank;
  reg rd_ap;
  wire rd_live = (rd_cnt < rd_lim);
  wire [3:0] bst_lim = {rd_age, 1'b0} + 4'h2;
  wire bst_hit = go & (cmd == `CMD_BST) & rd_live & ~rd_ap;
  reg [7:0] mem [0:255];
  wire [7:0] rd_addr = {rd_bank, burst_col(rd_base, rd_cnt, bl_mask)};

  // Read path: latency count, preamble, data per edge
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_wait <= 3'h0;
      rd_cnt <= 4'h0;
      rd_lim <= 4'h0;
      rd_age <= 3'h0;
      rd_base <= 6'h00;
      rd_bank <= 2'h0;
      rd_ap <= 1'b0;
      dq_out <= 8'h00;
      dq_oe_out <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe_out <= 1'b0;
    end else if (rd_ok) begin
      // A new READ cuts any burst still running
      rd_wait <= config_reg[`CFG_CL_BIT] ?
                 `CL25_EDGES : `CL2_EDGES;
      rd_cnt <= 4'h0;
      rd_lim <= bl_len;
      rd_age <= 3'h0;
      rd_base <= addr_s[5:0];
      rd_bank <= ba_s;
      rd_ap <= addr_s[`AP_BIT];
    end else begin
      if (bst_hit && bst_lim < rd_lim)
        rd_lim <= bst_lim;
      if (ck_rise && rd_live && rd_age < 3'h4)
        rd_age <= rd_age + 3'h1;
      if (ck_rise && rd_ap && {1'b0, rd_age} + 4'h1 ==
          {1'b0, bl_len[3:1]})
        rd_ap <= 1'b0;
      if (ck_edge) begin
        if (rd_live) begin
          if (rd_wait > 3'h1) begin
            rd_wait <= rd_wait - 3'h1;
            if (rd_wait == 3'h2) begin
              dqs_oe_out <= 1'b1;
              dqs_out <= 1'b0;
            end
          end else begin
            rd_wait <= 3'h0;
            dq_out <= mem[rd_addr];
            dq_oe_out <= 1'b1;
            dqs_out <= ~rd_cnt[0];
            dqs_oe_out <= 1'b1;
            rd_cnt <= rd_cnt + 4'h1;
          end
        end else if (dqs_oe_out) begin
          dq_oe_out <= 1'b0;
          dqs_oe_out <= 1'b0;
          dqs_out <= 1'b0;
        end
      end
    end
  end

  // Write burst state
  reg [3:0] wr_cnt;
  reg [3:0] wr_lim;
  reg [5:0] wr_base;
  reg [1:0] wr_bank;
  reg wr_ap;
  wire wr_live = (wr_cnt < wr_lim);
  wire wr_take = dqs_edge & wr_live & ~wr_ok;
  wire [7:0] wr_addr = {wr_bank, burst_col(wr_base, wr_cnt, bl_mask)};

  // Write path: one element per strobe edge
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      wr_cnt <= 4'h0;
      wr_lim <= 4'h0;
      wr_base <= 6'h00;
      wr_bank <= 2'h0;
      wr_ap <= 1'b0;
    end else if (wr_ok) begin
      wr_cnt <= 4'h0;
      wr_lim <= bl_len;
      wr_base <= addr_s[5:0];
      wr_bank <= ba_s;
      wr_ap <= addr_s[`AP_BIT];
    end else if (wr_take) begin
      wr_cnt <= wr_cnt + 4'h1;
      if (wr_cnt + 4'h1 == wr_lim)
        wr_ap <= 1'b0;
    end
  end

  // Array write, masked per element
  always @(posedge clock_in) begin
    if (wr_take && !dm_s)
      mem[wr_addr] <= dq_s;
  end

  // Auto precharge requests to the trackers, other banks stay free
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      ap_vec <= 4'h0;
    end else begin
      ap_vec <= 4'h0;
      if (!rd_ok && ck_rise && rd_ap && {1'b0, rd_age} + 4'h1 ==
          {1'b0, bl_len[3:1]})
        ap_vec[rd_bank] <= 1'b1;
      if (!wr_ok && wr_take && wr_ap && wr_cnt + 4'h1 == wr_lim)
        ap_vec[wr_bank] <= 1'b1;
    end
  end

  // Register port: configuration write, read data next cycle
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      config_reg <= `CONFIG_RESET;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == `REG_CONFIG)
        config_reg <= {5'h00, reg_wdata_in[2:0]};
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `REG_CONFIG: reg_rdata_out <= config_reg;
          `REG_STATUS: reg_rdata_out <= {rd_live, ref_busy, dll_ok,
                                          mode == M_SREF, bank_open};
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/ddr_engine_checker_props.sv
// Purpose: port checker for the DDR command engine
// Assumes: link clock period is eight system clocks
// Notes: bound to the engine at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ddr_engine_checker (
  input wire logic clock_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic [1:0] reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [7:0] reg_rdata_out, // Register read data
  input wire logic [7:0] dq_out, // Data out
  input wire logic dq_oe_out, // Data driven
  input wire logic dqs_out, // Strobe out
  input wire logic dqs_oe_out // Strobe driven
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // Read strobe framing and element pacing
  first_element_a: assert property (
    $rose(dqs_oe_out) |-> !dqs_out [*4] ##1 dqs_out)
    else $error("first element not one half period after preamble");
  postamble_low_a: assert property (
    $fell(dqs_oe_out) |-> !$past(dqs_out))
    else $error("strobe not low with last element");
  strobe_with_data_a: assert property (
    dq_oe_out |-> dqs_oe_out)
    else $error("data driven without strobe");
  enables_drop_a: assert property (
    $fell(dq_oe_out) |-> $fell(dqs_oe_out))
    else $error("data and strobe enables drop apart");
  element_hold_a: assert property (
    dqs_oe_out && $changed(dqs_out) |=> $stable(dqs_out) [*3])
    else $error("element shorter than half a link period");
  // Register port answers
  rdata_idle_a: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (
    reg_rd_in && reg_addr_in[1] |=> reg_rdata_out == 8'h00)
    else $error("unmapped address read not zero");
  cfg_readback_a: assert property (
    reg_wr_in && reg_addr_in == 2'h0 ##2 reg_rd_in && reg_addr_in == 2'h0
    |=> reg_rdata_out[2:0] == $past(reg_wdata_in[2:0], 3))
    else $error("config readback differs");
  cover property ($rose(dqs_oe_out));
  cover property (reg_rd_in && reg_addr_in[1]);
  cover property (reg_wr_in && reg_addr_in == 2'h0 ##2 reg_rd_in);
endmodule
bind ddr_command_engine ddr_engine_checker chk_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .dqs_out(dqs_out), .dqs_oe_out(dqs_oe_out)
);
`default_nettype wire

// file: sim/ddr_ctrl_model.sv
// Purpose: memory controller model driving the link pins
// Assumes: link clock runs free at 160 ns
// Notes: command pins and CKE change at the first system clock rise after a CK fall
`timescale 1ns/1ps
`default_nettype none
`include "ddr_map.vh"
module ddr_ctrl_model (
  input wire logic clock_in, // System clock
  output var logic ck_out, // Link clock
  output var logic cke_out, // Clock enable
  output var logic cs_n_out, // Chip select, active low
  output var logic ras_n_out, // Row strobe, active low
  output var logic cas_n_out, // Column strobe, active low
  output var logic we_n_out, // Write enable, active low
  output var logic [1:0] ba_out, // Bank
  output var logic [13:0] addr_out, // Address
  output var logic [7:0] dq_out, // Write data
  output var logic dqs_out, // Write strobe
  output var logic dm_out // Write mask
);
  time t_cmd = 0;
  // Free running clock, stable before any CKE rise
  initial begin
    ck_out = 1'b0;
    #7;
    forever #80 ck_out = ~ck_out;
  end
  // Idle pins
  initial begin
    {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h1F;
    {ba_out, addr_out, dq_out, dqs_out, dm_out} = 26'h0;
  end
  // One command per CK rise; a CK exceeds every spacing count
  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
    input logic [13:0] a, input logic cs_n);
    @(negedge ck_out);
    @(posedge clock_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= {cs_n, c};
    ba_out <= b;
    addr_out <= a;
    @(posedge ck_out);
    t_cmd = $time;
    repeat (2) @(posedge clock_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hF;
    addr_out <= ~a; // Released address shows its inverse
  endtask
  // CKE changes only on a CK fall
  task automatic set_cke(input logic v);
    @(negedge ck_out);
    @(posedge clock_in);
    cke_out <= v;
  endtask
  // Four elements, strobe edges centred on the data
  task automatic wdata(input logic [31:0] d, input logic [3:0] m);
    repeat (3) @(posedge clock_in);
    for (int k = 0; k < 4; k++) begin
      dq_out <= d[8*k +: 8];
      dm_out <= m[k];
      repeat (2) @(posedge clock_in);
      dqs_out <= ~dqs_out;
      repeat (2) @(posedge clock_in);
    end
    dq_out <= ~dq_out;
  endtask
endmodule
`default_nettype wire

// file: sim/ddr_command_engine_tb_top.sv
// Purpose: self-checking bench for the DDR command engine
// Assumes: x8 data, burst of four, 160 ns link clock
// Notes: read elements captured on each strobe change
`timescale 1ns/1ps
`default_nettype none
`include "ddr_map.vh"
module ddr_command_engine_tb_top;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] reg_addr_in = 2'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  wire logic [7:0] reg_rdata_out, dq_out, p_dq;
  wire logic dq_oe_out, dqs_out, dqs_oe_out, p_dqs, dm_in;
  wire logic ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
  wire logic [1:0] ba_in;
  wire logic [13:0] addr_in;
  wire logic [7:0] dq_in = dq_oe_out ? dq_out : p_dq;
  wire logic dqs_in = dqs_oe_out ? dqs_out : p_dqs;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] rq[$];
  logic last_dqs = 1'b0;
  logic oe_d = 1'b0;
  time t_pre = 0;
  always #10 clock_in = ~clock_in;
  ddr_command_engine uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .ck_in(ck_in), .cke_in(cke_in), .cs_n_in(cs_n_in), .ras_n_in(ras_n_in),
    .cas_n_in(cas_n_in), .we_n_in(we_n_in), .ba_in(ba_in),
    .addr_in(addr_in), .dq_in(dq_in), .dqs_in(dqs_in), .dm_in(dm_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dqs_out(dqs_out),
    .dqs_oe_out(dqs_oe_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
  ddr_ctrl_model ctl (.clock_in(clock_in), .ck_out(ck_in), .cke_out(cke_in),
    .cs_n_out(cs_n_in), .ras_n_out(ras_n_in), .cas_n_out(cas_n_in),
    .we_n_out(we_n_in), .ba_out(ba_in), .addr_out(addr_in), .dq_out(p_dq),
    .dqs_out(p_dqs), .dm_out(dm_in));
  // Read element capture and preamble time stamp
  always @(posedge clock_in) begin
    if (dqs_oe_out === 1'b1 && dqs_out !== last_dqs) rq.push_back(dq_out);
    if (dqs_oe_out === 1'b1 && oe_d === 1'b0) t_pre = $time;
    last_dqs <= dqs_out;
    oe_d <= dqs_oe_out;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e, string nm);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, e, reg_rdata_out);
  endtask
  task automatic st(input logic [7:0] e, input string nm);
    repeat (6) @(posedge clock_in);
    rd(2'h1, e, nm);
  endtask
  // READ, optional terminate one CK later, then compare elements
  task automatic rdb(input logic [1:0] b, input logic [13:0] a, logic bst,
    int n, logic [31:0] e, time lat, string nm);
    time t0;
    rq.delete();
    ctl.cmd(`CMD_READ, b, a, 1'b0);
    t0 = ctl.t_cmd;
    if (bst) ctl.cmd(`CMD_BST, 2'h0, 14'h0, 1'b0);
    repeat (60) @(posedge clock_in);
    chk({nm, " count"}, n, rq.size());
    for (int k = 0; k < n && k < rq.size(); k++) chk(nm, e[8*k +: 8], rq[k]);
    if (n > 0) chk({nm, " latency"}, 1, t_pre - t0 + 20 <= lat + 80);
    if (n > 0) chk({nm, " early"}, 1, t_pre - t0 + 20 >= lat);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    rd(2'h0, 8'h05, "config");
    rd(2'h1, 8'h20, "status");
    rd(2'h2, 8'h00, "unmapped");
    $display("test registers done");
    // Fill bank 1 columns 4..7, read back at CL 2.5 then CL 2
    ctl.cmd(`CMD_ACT, 2'h1, 14'h0123, 1'b0);
    st(8'h22, "open b1");
    ctl.cmd(`CMD_WRITE, 2'h1, 14'h0004, 1'b0);
    ctl.wdata(32'hA3A2A1A0, 4'h0);
    rdb(2'h1, 14'h0004, 1'b0, 4, 32'hA3A2A1A0, 380, "cl25");
    wr(2'h3, 8'h00);
    wr(2'h0, 8'hFC);
    rd(2'h0, 8'h04, "cl2 cfg");
    ctl.cmd(`CMD_WRITE, 2'h1, 14'h0004, 1'b0);
    ctl.wdata(32'hB3B2B1B0, 4'h4);
    rdb(2'h1, 14'h0006, 1'b0, 4, 32'hB1B0B3A2, 300, "wrap");
    rdb(2'h1, 14'h0004, 1'b1, 2, 32'h0000B1B0, 300, "bst");
    st(8'h22, "bst open");
    $display("test bursts done");
    // Refused and deselected commands, single and all-bank precharge
    ctl.cmd(`CMD_PRE, 2'h2, 14'h0000, 1'b0);
    ctl.cmd(`CMD_ACT, 2'h0, 14'h0000, 1'b1);
    st(8'h22, "pre idle");
    ctl.cmd(`CMD_PRE, 2'h1, 14'h0000, 1'b0);
    st(8'h20, "pre one");
    rdb(2'h1, 14'h0004, 1'b0, 0, 32'h0, 0, "closed");
    ctl.cmd(`CMD_ACT, 2'h0, 14'h0000, 1'b0);
    ctl.cmd(`CMD_ACT, 2'h1, 14'h0055, 1'b0);
    rdb(2'h1, 14'h0404, 1'b0, 4, 32'hB3A2B1B0, 300, "ap");
    st(8'h21, "ap closed");
    ctl.cmd(`CMD_REF, 2'h0, 14'h0000, 1'b0);
    rd(2'h1, 8'h21, "ref refused");
    ctl.cmd(`CMD_ACT, 2'h2, 14'h0000, 1'b0);
    ctl.cmd(`CMD_WRITE, 2'h2, 14'h0000, 1'b0);
    ctl.wdata(32'hC3C2C1C0, 4'h0);
    ctl.cmd(`CMD_PRE, 2'h3, 14'h0400, 1'b0);
    st(8'h20, "pre all");
    ctl.cmd(`CMD_REF, 2'h0, 14'h1234, 1'b0);
    rd(2'h1, 8'h60, "auto ref");
    $display("test precharge done");
    // Self refresh keeps data; READ waits for the DLL reset count
    ctl.set_cke(1'b0);
    ctl.cmd(`CMD_REF, 2'h0, 14'h0000, 1'b0);
    ctl.cmd(`CMD_ACT, 2'h2, 14'h0000, 1'b0);
    st(8'h10, "self ref");
    ctl.set_cke(1'b1);
    ctl.cmd(`CMD_NOP, 2'h0, 14'h0000, 1'b0);
    ctl.cmd(`CMD_LMR, 2'h0, 14'h0100, 1'b0);
    ctl.cmd(`CMD_ACT, 2'h2, 14'h0000, 1'b0);
    rdb(2'h2, 14'h0000, 1'b0, 0, 32'h0, 0, "no dll");
    repeat (1700) @(posedge clock_in);
    st(8'h24, "dll lock");
    rdb(2'h2, 14'h0000, 1'b0, 4, 32'hC3C2C1C0, 300, "kept");
    $display("test self refresh done");
    complete_run();
  end
endmodule
`default_nettype wire
